// ---- rtl/fbgp_cfg.svh ----
`ifndef FBGP_CFG_SVH
`define FBGP_CFG_SVH

`define FBGP_OFS_DONE_LOW   8'h60
`define FBGP_OFS_DONE_HIGH  8'h61
`define FBGP_OFS_TONE_CFG   8'h62
`define FBGP_OFS_LINKS_LOW  8'h63
`define FBGP_OFS_LINKS_HIGH 8'h64
`define FBGP_OFS_ONE_SHOT   8'h65
`define FBGP_OFS_PIN_DIR    8'h70
`define FBGP_OFS_PIN_TYPE   8'h71
`define FBGP_OFS_PIN_LEVEL  8'h72

`define FBGP_RST_BYTE       8'h00
`define FBGP_DUR_MSB        7
`define FBGP_DUR_LSB        5
`define FBGP_FREQ_MSB       4
`define FBGP_FREQ_LSB       0
`define FBGP_DUR_OFF        3'h0
`define FBGP_DUR_HOLD       3'h7
`define FBGP_DUR_SHIFT      2

`define FBGP_CLK_HZ         200000000
`define FBGP_MS_PER_S       1000
`define FBGP_TONE_STEP_HZ   125
`define FBGP_MS_CYCLES      (`FBGP_CLK_HZ / `FBGP_MS_PER_S)
`define FBGP_HALF_BASE      (`FBGP_CLK_HZ / (2 * `FBGP_TONE_STEP_HZ))

`endif

// ---- rtl/fbgp_pkg.sv ----
`default_nettype none
package fbgp_pkg;
  typedef enum logic [1:0] {
    FBGP_IDLE = 2'b01,
    FBGP_RUN  = 2'b10
  } fbgp_state_t;
  typedef logic [13:0] fbgp_sensor_t;
  typedef logic [7:0]  fbgp_byte_t;
endpackage
`default_nettype wire

// ---- rtl/fbgp_tone_if.sv ----
`default_nettype none
interface fbgp_tone_if;
  import fbgp_pkg::*;
  logic         start;
  logic [2:0]   dur_code;
  logic [4:0]   freq_code;
  fbgp_sensor_t links;
  fbgp_sensor_t touch;
  logic         active;
  logic         tone;
  modport ctrl (output start, output dur_code, output freq_code, output links,
                output touch, input active, input tone);
  modport gen  (input start, input dur_code, input freq_code, input links,
                input touch, output active, output tone);
endinterface
`default_nettype wire

// ---- rtl/fbgp_tone.sv ----
`include "fbgp_cfg.svh"
`default_nettype none
module fbgp_tone #(
  parameter int unsigned MS_CYCLES = `FBGP_MS_CYCLES,
  parameter int unsigned HALF_BASE = `FBGP_HALF_BASE
) (
  input  wire logic     clk,
  input  wire logic     rst,
  fbgp_tone_if.gen      tif
);
  import fbgp_pkg::*;

  // ----------------------------------------
  // Activation state, settings latched at start
  // ----------------------------------------
  fbgp_state_t  state;
  logic [2:0]   dur_lat;
  logic [4:0]   freq_lat;
  fbgp_sensor_t links_lat;
  logic [31:0]  pre;
  logic [8:0]   ms_cnt;
  logic [31:0]  acc;
  logic         wave;

  wire          held     = |(tif.touch & links_lat);
  // Shift amount kept at four bits so code 6 reaches 256 ms without wrapping
  wire [8:0]    len_ms   = 9'(9'h1 << (4'(dur_lat) + 4'(`FBGP_DUR_SHIFT)));
  wire          ms_tick  = (pre == MS_CYCLES - 1);
  wire          hold_end = (dur_lat == `FBGP_DUR_HOLD) && !held;
  wire          time_end = (dur_lat != `FBGP_DUR_HOLD) && ms_tick && (ms_cnt == len_ms - 9'h1);
  wire [31:0]   acc_sum  = acc + 32'(freq_lat);
  wire          wrap     = (acc_sum >= HALF_BASE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= FBGP_IDLE;
      dur_lat   <= `FBGP_DUR_OFF;
      freq_lat  <= 5'h00;
      links_lat <= 14'h0000;
      pre       <= 32'h0000_0000;
      ms_cnt    <= 9'h000;
      acc       <= 32'h0000_0000;
      wave      <= 1'b0;
    end else if (tif.start) begin
      dur_lat   <= tif.dur_code;
      freq_lat  <= tif.freq_code;
      links_lat <= tif.links;
      pre       <= 32'h0000_0000;
      ms_cnt    <= 9'h000;
      acc       <= 32'h0000_0000;
      wave      <= 1'b1;
      state     <= (tif.dur_code == `FBGP_DUR_OFF) ? FBGP_IDLE : FBGP_RUN;
    end else begin
      case (state)
        FBGP_IDLE: begin
          wave <= 1'b0;
        end
        FBGP_RUN: begin
          pre <= ms_tick ? 32'h0000_0000 : pre + 32'h1;
          if (ms_tick) begin
            ms_cnt <= ms_cnt + 9'h001;
          end
          acc <= wrap ? acc_sum - HALF_BASE : acc_sum;
          if (wrap) begin
            wave <= ~wave;
          end
          if (hold_end || time_end) begin
            state <= FBGP_IDLE;
          end
        end
        default: begin
          state <= FBGP_IDLE;
        end
      endcase
    end
  end

  assign tif.active = (state == FBGP_RUN);
  assign tif.tone   = tif.active && ((freq_lat == 5'h00) || wave);
endmodule
`default_nettype wire

// ---- rtl/fbgp_top.sv ----
`include "fbgp_cfg.svh"
`default_nettype none
module fbgp_top #(
  parameter int unsigned MS_CYCLES = `FBGP_MS_CYCLES,
  parameter int unsigned HALF_BASE = `FBGP_HALF_BASE
) (
  input  wire logic            CORE_CLK,
  input  wire logic            RST,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic            REG_WR_EN,
  input  wire fbgp_pkg::fbgp_byte_t REG_WDATA,
  input  wire logic            REG_RD_EN,
  output logic [7:0]           REG_RDATA,
  input  wire logic            MAIN_IRQ_CLEAR,
  input  wire logic            DEEP_SLEEP_REQUEST,
  input  wire logic [10:0]     LAMP_BEHAVIOUR_DONE,
  input  wire logic [10:0]     LAMP_SENSOR_LINKED,
  input  wire logic [7:0]      LAMP_OUTPUT_CONTROL,
  input  wire logic [7:0]      LAMP_LINKED_TOUCH,
  input  wire fbgp_pkg::fbgp_sensor_t TOUCH_INPUT,
  input  wire logic [7:0]      LAMP_PIN_IN,
  output logic [7:0]           LAMP_PIN_OUT,
  output logic [7:0]           LAMP_PIN_OE,
  input  wire logic [7:0]      PIN_IRQ_ENABLE,
  input  wire logic [7:0]      PIN_CHANGE_CLEAR,
  output logic [7:0]           PIN_CHANGE_FLAG,
  output logic                 PIN_IRQ,
  output logic                 TONE_OUT
);
  import fbgp_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  fbgp_byte_t   tone_output_config;
  fbgp_byte_t   tone_sensor_links_low;
  fbgp_byte_t   tone_sensor_links_high;
  fbgp_byte_t   pin_direction_select;
  fbgp_byte_t   pin_drive_type_select;
  fbgp_byte_t   pin_level_readback;
  logic [10:0]  lamp_behaviour_done;
  logic [7:0]   pin_change_flag;
  logic [7:0]   pin_sync1;
  logic [7:0]   pin_prev;
  fbgp_sensor_t touch_prev;
  logic         sleep_prev;
  logic         tone_q;

  fbgp_tone_if  tif ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire          wr_cfg      = REG_WR_EN && (REG_ADDR == `FBGP_OFS_TONE_CFG);
  wire          wr_links_lo = REG_WR_EN && (REG_ADDR == `FBGP_OFS_LINKS_LOW);
  wire          wr_links_hi = REG_WR_EN && (REG_ADDR == `FBGP_OFS_LINKS_HIGH);
  wire          wr_shot     = REG_WR_EN && (REG_ADDR == `FBGP_OFS_ONE_SHOT);
  wire          wr_dir      = REG_WR_EN && (REG_ADDR == `FBGP_OFS_PIN_DIR);
  wire          wr_type     = REG_WR_EN && (REG_ADDR == `FBGP_OFS_PIN_TYPE);

  // ----------------------------------------
  // Tone trigger
  // ----------------------------------------
  wire [2:0]    dur_code    = tone_output_config[`FBGP_DUR_MSB:`FBGP_DUR_LSB];
  wire [4:0]    freq_code   = tone_output_config[`FBGP_FREQ_MSB:`FBGP_FREQ_LSB];
  wire [13:0]   links       = {tone_sensor_links_high[6:0], tone_sensor_links_low[6:0]};
  wire          touch_fire  = |(TOUCH_INPUT & ~touch_prev & links);
  wire          shot_fire   = wr_shot && (dur_code != `FBGP_DUR_OFF)
                              && (dur_code != `FBGP_DUR_HOLD);

  assign tif.start     = touch_fire || shot_fire;
  assign tif.dur_code  = dur_code;
  assign tif.freq_code = freq_code;
  assign tif.links     = links;
  assign tif.touch     = TOUCH_INPUT;

  fbgp_tone #(
    .MS_CYCLES (MS_CYCLES),
    .HALF_BASE (HALF_BASE)
  ) u_tone (
    .clk (CORE_CLK),
    .rst (RST),
    .tif (tif)
  );

  // ----------------------------------------
  // Lamp done flags
  // ----------------------------------------
  wire          sleep_rise  = DEEP_SLEEP_REQUEST && !sleep_prev;
  wire          done_clear  = MAIN_IRQ_CLEAR || sleep_rise;
  wire [10:0]   done_set    = LAMP_BEHAVIOUR_DONE & ~LAMP_SENSOR_LINKED;
  wire [10:0]   next_done   = (done_clear ? 11'h000 : lamp_behaviour_done) | done_set;

  // ----------------------------------------
  // Pin drive and sampling
  // ----------------------------------------
  wire [7:0]    lamp_active = LAMP_OUTPUT_CONTROL | LAMP_LINKED_TOUCH;
  wire [7:0]    pin_changed = (pin_level_readback ^ pin_prev) & ~pin_direction_select;
  wire [7:0]    next_flag   = (pin_change_flag & ~PIN_CHANGE_CLEAR) | pin_changed;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          LAMP_PIN_OUT[g] <= 1'b0;
          LAMP_PIN_OE[g]  <= 1'b0;
        end else if (!pin_direction_select[g]) begin
          LAMP_PIN_OUT[g] <= 1'b0;
          LAMP_PIN_OE[g]  <= 1'b0;
        end else if (pin_drive_type_select[g]) begin
          LAMP_PIN_OUT[g] <= lamp_active[g];
          LAMP_PIN_OE[g]  <= 1'b1;
        end else begin
          LAMP_PIN_OUT[g] <= 1'b0;
          LAMP_PIN_OE[g]  <= lamp_active[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (REG_ADDR)
      `FBGP_OFS_DONE_LOW:   rd_mux = lamp_behaviour_done[7:0];
      `FBGP_OFS_DONE_HIGH:  rd_mux = {5'h00, lamp_behaviour_done[10:8]};
      `FBGP_OFS_TONE_CFG:   rd_mux = tone_output_config;
      `FBGP_OFS_LINKS_LOW:  rd_mux = {1'b0, tone_sensor_links_low[6:0]};
      `FBGP_OFS_LINKS_HIGH: rd_mux = {1'b0, tone_sensor_links_high[6:0]};
      `FBGP_OFS_PIN_DIR:    rd_mux = pin_direction_select;
      `FBGP_OFS_PIN_TYPE:   rd_mux = pin_drive_type_select;
      `FBGP_OFS_PIN_LEVEL:  rd_mux = pin_level_readback;
      default:              rd_mux = `FBGP_RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tone_output_config     <= `FBGP_RST_BYTE;
      tone_sensor_links_low  <= `FBGP_RST_BYTE;
      tone_sensor_links_high <= `FBGP_RST_BYTE;
      pin_direction_select   <= `FBGP_RST_BYTE;
      pin_drive_type_select  <= `FBGP_RST_BYTE;
    end else begin
      if (wr_cfg) begin
        tone_output_config <= REG_WDATA;
      end
      if (wr_links_lo) begin
        tone_sensor_links_low <= REG_WDATA;
      end
      if (wr_links_hi) begin
        tone_sensor_links_high <= REG_WDATA;
      end
      if (wr_dir) begin
        pin_direction_select <= REG_WDATA;
      end
      if (wr_type) begin
        pin_drive_type_select <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_sync1          <= 8'h00;
      pin_level_readback <= 8'h00;
      pin_prev           <= 8'h00;
      pin_change_flag    <= 8'h00;
      lamp_behaviour_done <= 11'h000;
      touch_prev         <= 14'h0000;
      sleep_prev         <= 1'b0;
      REG_RDATA          <= `FBGP_RST_BYTE;
      PIN_IRQ            <= 1'b0;
      tone_q             <= 1'b0;
    end else begin
      pin_sync1           <= LAMP_PIN_IN;
      pin_level_readback  <= pin_sync1;
      pin_prev            <= pin_level_readback;
      pin_change_flag     <= next_flag;
      lamp_behaviour_done <= next_done;
      touch_prev          <= TOUCH_INPUT;
      sleep_prev          <= DEEP_SLEEP_REQUEST;
      REG_RDATA           <= REG_RD_EN ? rd_mux : REG_RDATA;
      PIN_IRQ             <= |(next_flag & PIN_IRQ_ENABLE);
      tone_q              <= tif.tone;
    end
  end

  assign PIN_CHANGE_FLAG = pin_change_flag;
  assign TONE_OUT        = tone_q;
endmodule
`default_nettype wire

// ---- tb/fbgp_top_checker.sv ----
`default_nettype none
module fbgp_top_checker #(
  parameter int unsigned MS_CYCLES = 200000,
  parameter int unsigned HALF_BASE = 800000
) (
  input wire logic                 CORE_CLK,
  input wire logic                 RST,
  input wire logic [7:0]           REG_ADDR,
  input wire logic                 REG_WR_EN,
  input wire fbgp_pkg::fbgp_byte_t REG_WDATA,
  input wire logic                 REG_RD_EN,
  input wire logic [7:0]           REG_RDATA,
  input wire logic                 MAIN_IRQ_CLEAR,
  input wire logic                 DEEP_SLEEP_REQUEST,
  input wire logic [10:0]          LAMP_BEHAVIOUR_DONE,
  input wire logic [7:0]           LAMP_PIN_OE,
  input wire logic [7:0]           PIN_IRQ_ENABLE,
  input wire logic [7:0]           PIN_CHANGE_CLEAR,
  input wire logic [7:0]           PIN_CHANGE_FLAG,
  input wire logic                 PIN_IRQ,
  input wire logic                 TONE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbgp_pkg::*;
  wire quiet = LAMP_BEHAVIOUR_DONE == 11'h000;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_dc_cfg;
    REG_WR_EN && REG_ADDR == 8'h62 && REG_WDATA == 8'h20;
  endsequence
  sequence s_bad_cfg;
    REG_WR_EN && REG_ADDR == 8'h62 && REG_WDATA[7:5] inside {3'h0, 3'h7};
  endsequence
  sequence s_rd_done;
    quiet && REG_RD_EN && REG_ADDR == 8'h60;
  endsequence
  property p_rd_zero;
    REG_RD_EN && !(REG_ADDR inside {[8'h60:8'h64], [8'h70:8'h72]}) |=> REG_RDATA == 8'h00;
  endproperty
  property p_shot_dc;
    s_dc_cfg ##2 REG_WR_EN && REG_ADDR == 8'h65 |-> ##3 TONE_OUT [*8];
  endproperty
  property p_shot_off;
    s_bad_cfg ##2 REG_WR_EN && REG_ADDR == 8'h65 && !TONE_OUT |=> !TONE_OUT [*4];
  endproperty
  property p_clr_irq;
    quiet && MAIN_IRQ_CLEAR ##1 quiet ##1 s_rd_done |=> REG_RDATA == 8'h00;
  endproperty
  property p_clr_sleep;
    quiet && $rose(DEEP_SLEEP_REQUEST) ##1 quiet ##1 s_rd_done |=> REG_RDATA == 8'h00;
  endproperty
  property p_dir_in;
    REG_WR_EN && REG_ADDR == 8'h70 |-> ##2 (LAMP_PIN_OE & ~$past(REG_WDATA, 2)) == 8'h00;
  endproperty
  property p_irq;
    $stable(PIN_IRQ_ENABLE) |-> PIN_IRQ == |(PIN_CHANGE_FLAG & PIN_IRQ_ENABLE);
  endproperty
  property p_flag_hold;
    (~PIN_CHANGE_FLAG & $past(PIN_CHANGE_FLAG) & ~$past(PIN_CHANGE_CLEAR)) == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
  a_shot_dc: assert property (p_shot_dc) else $error("one-shot level short");
  a_shot_off: assert property (p_shot_off) else $error("one-shot not ignored");
  a_clr_irq: assert property (p_clr_irq) else $error("done not cleared");
  a_clr_sleep: assert property (p_clr_sleep) else $error("done not cleared");
  a_dir_in: assert property (p_dir_in) else $error("input pin driven");
  a_irq: assert property (p_irq) else $error("pin interrupt wrong");
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
endmodule
bind fbgp_top fbgp_top_checker #(.MS_CYCLES(MS_CYCLES), .HALF_BASE(HALF_BASE)) u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR_EN(REG_WR_EN),
  .REG_WDATA(REG_WDATA), .REG_RD_EN(REG_RD_EN), .REG_RDATA(REG_RDATA),
  .MAIN_IRQ_CLEAR(MAIN_IRQ_CLEAR), .DEEP_SLEEP_REQUEST(DEEP_SLEEP_REQUEST),
  .LAMP_BEHAVIOUR_DONE(LAMP_BEHAVIOUR_DONE), .LAMP_PIN_OE(LAMP_PIN_OE),
  .PIN_IRQ_ENABLE(PIN_IRQ_ENABLE), .PIN_CHANGE_CLEAR(PIN_CHANGE_CLEAR),
  .PIN_CHANGE_FLAG(PIN_CHANGE_FLAG), .PIN_IRQ(PIN_IRQ), .TONE_OUT(TONE_OUT)
);
`default_nettype wire

// ---- tb/fbgp_pad_model.sv ----
`default_nettype none
module fbgp_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_value,
  output logic [7:0]      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins float up to the external pull-up
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~ext_drive) | (~pin_oe & ext_value);
endmodule
`default_nettype wire

// ---- tb/fbgp_tb_top.sv ----
`default_nettype none
module fbgp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  localparam int HB = 40;
  logic clk = 0, rst = 1, we = 0, re = 0, mic = 0, dsr = 0;
  logic [7:0] a = 8'h00, d = 8'h00, ctl = 8'h00, lt = 8'h00, ien = 8'h00, pcc = 8'h00;
  logic [7:0] xd = 8'hFF, xv = 8'h00, rdat, pout, poe, pin, flg;
  logic [10:0] dn = 11'h000, lk = 11'h000;
  logic [13:0] tch = 14'h0000;
  logic [4:0] fq [2] = '{5'h01, 5'h1F};
  logic [7:0] ra [10] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h70, 8'h71, 8'h72};
  logic irq, tone;
  int num_errors = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  fbgp_top #(.MS_CYCLES(MS), .HALF_BASE(HB)) dut (
    .CORE_CLK(clk), .RST(rst), .REG_ADDR(a), .REG_WR_EN(we), .REG_WDATA(d), .REG_RD_EN(re),
    .REG_RDATA(rdat), .MAIN_IRQ_CLEAR(mic), .DEEP_SLEEP_REQUEST(dsr),
    .LAMP_BEHAVIOUR_DONE(dn), .LAMP_SENSOR_LINKED(lk), .LAMP_OUTPUT_CONTROL(ctl),
    .LAMP_LINKED_TOUCH(lt), .TOUCH_INPUT(tch), .LAMP_PIN_IN(pin), .LAMP_PIN_OUT(pout),
    .LAMP_PIN_OE(poe), .PIN_IRQ_ENABLE(ien), .PIN_CHANGE_CLEAR(pcc),
    .PIN_CHANGE_FLAG(flg), .PIN_IRQ(irq), .TONE_OUT(tone));
  fbgp_pad_model pad (.pin_out(pout), .pin_oe(poe), .ext_drive(xd), .ext_value(xv),
    .pin_level(pin));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk);
    a = ad;
    d = dt;
    we = 1;
    @(negedge clk);
    we = 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
    @(negedge clk);
    a = ad;
    re = 1;
    @(negedge clk);
    re = 0;
    cmp("rdata", {8'h00, ex}, {8'h00, rdat});
  endtask
  task automatic rise();
    int i;
    i = 0;
    while (tone !== 1'b1 && i < 9) begin
      @(negedge clk);
      i++;
    end
    if (i == 9) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic cnt(output int n);
    n = 0;
    while (tone === 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (n == 9000) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic t_regs();
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'h62, 8'hFF);
    wr(8'h63, 8'hFF);
    wr(8'h64, 8'hFF);
    wr(8'h60, 8'hFF);
    wr(8'h72, 8'hFF);
    rd(8'h62, 8'hFF);
    rd(8'h63, 8'h7F);
    rd(8'h64, 8'h7F);
    rd(8'h60, 8'h00);
    rd(8'h72, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h63, 8'h00);
    wr(8'h64, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_tone();
    int n;
    int e;
    logic v;
    for (int c = 1; c < 7; c++) begin
      wr(8'h62, {c[2:0], 5'h00});
      wr(8'h65, 8'h01);
      rise();
      cnt(n);
      cmp("tone_len", 16'((1 << (c + 2)) * MS), 16'(n));
    end
    foreach (fq[i]) begin
      wr(8'h62, {3'h1, fq[i]});
      wr(8'h65, 8'h01);
      rise();
      n = 0;
      e = 8 * MS * int'(fq[i]) / HB;
      repeat (8 * MS) begin
        v = tone;
        @(negedge clk);
        n += int'(tone !== v);
      end
      cmp("tone_edges", 16'h0001, {15'h0000, n >= e - 2 && n <= e + 2});
      cy(4);
    end
    $display("t_tone done");
  endtask
  task automatic t_touch();
    int n;
    wr(8'h62, 8'h20);
    wr(8'h63, 8'h01);
    tch = 14'h0002;
    cy(10);
    cmp("tone", 16'h0000, {15'h0000, tone});
    tch = 14'h0003;
    rise();
    cy(50);
    wr(8'h62, 8'h40);
    cnt(n);
    cmp("tone_len", 16'd108, 16'(n));
    tch = 14'h0000;
    cy(2);
    tch = 14'h0001;
    rise();
    cy(100);
    tch = 14'h0000;
    cy(2);
    tch = 14'h0001;
    cnt(n);
    cmp("tone_restart", 16'h0001, {15'h0000, n >= 319 && n <= 324});
    tch = 14'h0000;
    $display("t_touch done");
  endtask
  task automatic t_hold();
    wr(8'h62, 8'hE0);
    tch = 14'h0001;
    rise();
    cy(40);
    cmp("tone", 16'h0001, {15'h0000, tone});
    tch = 14'h0000;
    cy(4);
    cmp("tone", 16'h0000, {15'h0000, tone});
    wr(8'h62, 8'hE0);
    wr(8'h65, 8'h01);
    cy(6);
    cmp("tone", 16'h0000, {15'h0000, tone});
    rd(8'h65, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h65, 8'h01);
    tch = 14'h0001;
    cy(6);
    cmp("tone", 16'h0000, {15'h0000, tone});
    tch = 14'h0000;
    wr(8'h63, 8'h00);
    $display("t_hold done");
  endtask
  task automatic t_pins();
    xd = 8'h00;
    ctl = 8'h33;
    lt = 8'h40;
    wr(8'h71, 8'h0F);
    wr(8'h70, 8'hFF);
    cy(2);
    cmp("pin_oe", 16'h007F, {8'h00, poe});
    cmp("pin_out", 16'h0003, {8'h00, pout});
    cy(2);
    rd(8'h72, 8'h83);
    wr(8'h70, 8'h00);
    cy(2);
    cmp("pin_oe", 16'h0000, {8'h00, poe});
    $display("t_pins done");
  endtask
  task automatic t_gpio();
    xd = 8'hFF;
    ctl = 8'h00;
    lt = 8'h00;
    ien = 8'h01;
    cy(4);
    pcc = 8'hFF;
    cy(1);
    pcc = 8'h00;
    xv = 8'h05;
    cy(4);
    cmp("flag", 16'h0005, {8'h00, flg});
    cmp("irq", 16'h0001, {15'h0000, irq});
    pcc = 8'h01;
    cy(1);
    pcc = 8'h00;
    cy(1);
    cmp("flag", 16'h0004, {8'h00, flg});
    cmp("irq", 16'h0000, {15'h0000, irq});
    wr(8'h71, 8'h00);
    wr(8'h70, 8'h02);
    xv = 8'h07;
    cy(4);
    cmp("flag", 16'h0004, {8'h00, flg});
    rd(8'h72, 8'h07);
    wr(8'h70, 8'h00);
    $display("t_gpio done");
  endtask
  task automatic t_done();
    lk = 11'h002;
    dn = 11'h203;
    cy(1);
    dn = 11'h000;
    rd(8'h60, 8'h01);
    rd(8'h61, 8'h02);
    mic = 1;
    cy(1);
    mic = 0;
    rd(8'h60, 8'h00);
    dn = 11'h001;
    cy(1);
    dn = 11'h000;
    rd(8'h60, 8'h01);
    dsr = 1;
    cy(1);
    rd(8'h60, 8'h00);
    dsr = 0;
    lk = 11'h000;
    $display("t_done done");
  endtask
  initial begin
    cy(6);
    rst = 0;
    cy(2);
    t_regs();
    t_tone();
    t_touch();
    t_hold();
    t_pins();
    t_gpio();
    t_done();
    complete_run();
  end
endmodule
`default_nettype wire
